// [rtl/remote_bus_pkg.sv]
package remote_bus_pkg;

	// Input buffer and bus address range
	localparam int         BUF_DEPTH = 128;
	localparam logic [4:0] ADDR_MAX  = 5'h1E;
	localparam logic [4:0] ADDR_RST  = 5'h02;

	// Register offsets
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_STAT = 5'h04;
	localparam logic [4:0] OFS_RXD  = 5'h08;
	localparam logic [4:0] OFS_TXD  = 5'h0C;
	localparam logic [4:0] OFS_STB  = 5'h10;
	localparam logic [4:0] OFS_EVT  = 5'h14;

	// Field positions
	localparam int CTRL_TERM_LSB = 5;
	localparam int CTRL_EOI_BIT  = 7;
	localparam int TXD_LAST_BIT  = 8;
	localparam int STB_SRQ_BIT   = 6;
	localparam int STB_RQS_BIT   = 6;
	localparam int RXD_VALID_BIT = 8;

	// Reset values
	localparam logic [1:0] TERM_RST = 2'h0;
	localparam logic       EOI_RST  = 1'b1;

	// Response terminator choices
	localparam logic [1:0] TERM_CRLF = 2'h0;
	localparam logic [1:0] TERM_LF   = 2'h1;
	localparam logic [1:0] TERM_CR   = 2'h2;
	localparam logic [1:0] TERM_NONE = 2'h3;

	// Bus interface messages
	localparam logic [6:0] MSG_GTL  = 7'h01;
	localparam logic [6:0] MSG_SDC  = 7'h04;
	localparam logic [6:0] MSG_LLO  = 7'h11;
	localparam logic [6:0] MSG_DCL  = 7'h14;
	localparam logic [6:0] MSG_SPE  = 7'h18;
	localparam logic [6:0] MSG_SPD  = 7'h19;
	localparam logic [6:0] MSG_UNL  = 7'h3F;
	localparam logic [6:0] MSG_UNT  = 7'h5F;
	localparam logic [1:0] GRP_LAD  = 2'h1;
	localparam logic [1:0] GRP_TAD  = 2'h2;

	// Characters
	localparam logic [7:0] CHR_LF   = 8'h0A;
	localparam logic [7:0] CHR_CR   = 8'h0D;
	localparam logic [7:0] CHR_EXEC = 8'h58;
	localparam logic [7:0] CHR_LO   = 8'h20;
	localparam logic [7:0] CHR_HI   = 8'h7E;

	typedef enum logic [1:0] {
		AH_IDLE = 2'b00,
		AH_RDY  = 2'b01,
		AH_ACC  = 2'b10
	} ah_state_t;

	typedef enum logic [1:0] {
		SH_IDLE = 2'b00,
		SH_SET  = 2'b01,
		SH_DAV  = 2'b10
	} sh_state_t;

endpackage : remote_bus_pkg

// [rtl/remote_local_bus_interface.sv]
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module remote_local_bus_interface #(
	parameter int DEPTH = remote_bus_pkg::BUF_DEPTH
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic [7:0]  dio_n_i,
	output logic      [7:0]  dio_n_o,
	output logic      [7:0]  dio_n_oe_n,
	input  wire logic        dav_n_i,
	output logic             dav_n_o,
	output logic             dav_n_oe_n,
	input  wire logic        nrfd_n_i,
	output logic             nrfd_n_o,
	output logic             nrfd_n_oe_n,
	input  wire logic        ndac_n_i,
	output logic             ndac_n_o,
	output logic             ndac_n_oe_n,
	input  wire logic        eoi_n_i,
	output logic             eoi_n_o,
	output logic             eoi_n_oe_n,
	output logic             srq_n_o,
	output logic             srq_n_oe_n,
	input  wire logic        atn_n_i,
	input  wire logic        ifc_n_i,
	input  wire logic        ren_n_i,
	input  wire logic        usb_attached,
	input  wire logic [7:0]  usb_rx_data,
	input  wire logic        usb_rx_valid,
	output logic             usb_rx_ready,
	output logic      [7:0]  usb_tx_data,
	output logic             usb_tx_valid,
	input  wire logic        usb_tx_ready,
	input  wire logic        panel_op,
	input  wire logic        panel_browse,
	input  wire logic        panel_local,
	output logic             panel_op_ok,
	output logic             remote_ind,
	output logic             settings_restore
);
	localparam int PW = $clog2(DEPTH) + 1;

	generate
		if (DEPTH < 2 || DEPTH > 128 || (1 << (PW - 1)) != DEPTH) begin : g_bad_depth
			$error("DEPTH must be a power of two from 2 to 128");
		end
	endgenerate

	// Open-collector drive: only pull low
	assign dio_n_o  = 8'h00;
	assign dav_n_o  = 1'b0;
	assign nrfd_n_o = 1'b0;
	assign ndac_n_o = 1'b0;
	assign eoi_n_o  = 1'b0;
	assign srq_n_o  = 1'b0;

	logic        atn, ifc, ren, eoi_in;
	logic [7:0]  bus_byte;
	assign atn      = ~atn_n_i;
	assign ifc      = ~ifc_n_i;
	assign ren      = ~ren_n_i;
	assign eoi_in   = ~eoi_n_i;
	assign bus_byte = ~dio_n_i;

	logic [4:0]  addr_q;
	logic [1:0]  term_q;
	logic        eoi_en_q;
	logic        listen_q, talk_q, spoll_q;
	logic        remote_q, llo_q, link_usb_q;
	logic        ren_prev_q, usb_prev_q;
	logic [5:0]  stb_q;
	logic        rqs_q;
	logic [2:0]  evt_q;
	logic        restore_q;
	remote_bus_pkg::ah_state_t ah_q;
	remote_bus_pkg::sh_state_t sh_q;

	// Receive buffer
	logic [7:0]    mem [DEPTH];
	logic [PW-1:0] wp_q, cp_q, rp_q;
	logic          err_q;
	logic [PW-1:0] used;
	logic          full;
	assign used = wp_q - rp_q;
	assign full = used[PW-1];

	// Acceptor handshake
	logic       ah_act, ah_lsn, ah_take, cmd_v, gp_data_v;
	logic [6:0] cmd;
	logic       addr_hit;
	assign ah_lsn    = ~ifc & (atn | listen_q);
	assign ah_act    = ~ifc & (atn | (listen_q & ~full));
	assign ah_take   = ah_act & (ah_q == remote_bus_pkg::AH_RDY) & ~dav_n_i;
	assign cmd_v     = ah_take & atn;
	assign gp_data_v = ah_take & ~atn & listen_q;
	assign cmd       = bus_byte[6:0];
	assign addr_hit  = cmd[4:0] == addr_q;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ah_q <= remote_bus_pkg::AH_IDLE;
		end else if (ifc) begin
			ah_q <= remote_bus_pkg::AH_IDLE;
		end else begin
			case (ah_q)
				remote_bus_pkg::AH_IDLE: begin
					if (ah_act && dav_n_i) begin
						ah_q <= remote_bus_pkg::AH_RDY;
					end
				end
				remote_bus_pkg::AH_RDY: begin
					if (!ah_act) begin
						ah_q <= remote_bus_pkg::AH_IDLE;
					end else if (!dav_n_i) begin
						ah_q <= remote_bus_pkg::AH_ACC;
					end
				end
				remote_bus_pkg::AH_ACC: begin
					if (dav_n_i) begin
						ah_q <= remote_bus_pkg::AH_IDLE;
					end
				end
				default: ah_q <= remote_bus_pkg::AH_IDLE;
			endcase
		end
	end

	// Full buffer keeps ready low so no byte is lost
	assign nrfd_n_oe_n = ~(ah_lsn && !(ah_act && ah_q == remote_bus_pkg::AH_RDY));
	assign ndac_n_oe_n = ~(ah_lsn && ah_q != remote_bus_pkg::AH_ACC);

	// Interface messages
	logic mla, mta, gtl_hit, dev_clr;
	assign mla     = cmd_v && cmd[6:5] == remote_bus_pkg::GRP_LAD && addr_hit;
	assign mta     = cmd_v && cmd[6:5] == remote_bus_pkg::GRP_TAD && addr_hit;
	assign gtl_hit = cmd_v && cmd == remote_bus_pkg::MSG_GTL && listen_q;
	assign dev_clr = cmd_v && (cmd == remote_bus_pkg::MSG_DCL ||
		(cmd == remote_bus_pkg::MSG_SDC && listen_q));

	// Addressing and serial poll mode; other messages ignored
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			listen_q <= 1'b0;
			talk_q   <= 1'b0;
			spoll_q  <= 1'b0;
		end else if (ifc) begin
			listen_q <= 1'b0;
			talk_q   <= 1'b0;
			spoll_q  <= 1'b0;
		end else if (cmd_v) begin
			if (cmd == remote_bus_pkg::MSG_UNL) begin
				listen_q <= 1'b0;
			end
			if (cmd == remote_bus_pkg::MSG_UNT) begin
				talk_q <= 1'b0;
			end
			if (mla) begin
				listen_q <= 1'b1;
				talk_q   <= 1'b0;
			end
			if (cmd_v && cmd[6:5] == remote_bus_pkg::GRP_TAD) begin
				talk_q <= addr_hit;
				if (addr_hit) begin
					listen_q <= 1'b0;
				end
			end
			if (cmd == remote_bus_pkg::MSG_SPE) begin
				spoll_q <= 1'b1;
			end
			if (cmd == remote_bus_pkg::MSG_SPD) begin
				spoll_q <= 1'b0;
			end
		end
	end
	// Parallel poll, trigger, controller and secondary codes fall through unused

	// Response sequencer with terminator
	logic [7:0] txb_q;
	logic       txv_q, txl_q;
	logic [1:0] tseq_q;
	logic       out_v, out_end, tx_take, sh_sp_q, sh_done;
	logic [7:0] out_b, term_b;
	assign term_b  = (tseq_q == 2'h2 || term_q == remote_bus_pkg::TERM_LF) ?
		remote_bus_pkg::CHR_LF : remote_bus_pkg::CHR_CR;
	assign out_v   = txv_q | (tseq_q != 2'h0);
	assign out_b   = txv_q ? txb_q : term_b;
	assign out_end = txv_q ? (txl_q && term_q == remote_bus_pkg::TERM_NONE) :
		(tseq_q == 2'h2 || term_q != remote_bus_pkg::TERM_CRLF);
	assign usb_tx_data  = out_b;
	assign usb_tx_valid = out_v & link_usb_q & usb_attached;
	assign tx_take      = (sh_done & ~sh_sp_q) | (usb_tx_valid & usb_tx_ready);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			txb_q  <= 8'h00;
			txv_q  <= 1'b0;
			txl_q  <= 1'b0;
			tseq_q <= 2'h0;
		end else if (dev_clr) begin
			txv_q  <= 1'b0;
			tseq_q <= 2'h0;
		end else if (tx_take) begin
			if (txv_q) begin
				txv_q <= 1'b0;
				if (txl_q && term_q != remote_bus_pkg::TERM_NONE) begin
					tseq_q <= 2'h1;
				end
			end else if (tseq_q == 2'h1 && term_q == remote_bus_pkg::TERM_CRLF) begin
				tseq_q <= 2'h2;
			end else begin
				tseq_q <= 2'h0;
			end
		end else if (reg_wr && reg_addr == remote_bus_pkg::OFS_TXD && !out_v) begin
			txb_q <= reg_wdata[7:0];
			txl_q <= reg_wdata[remote_bus_pkg::TXD_LAST_BIT];
			txv_q <= 1'b1;
		end
	end

	// Source handshake
	logic       sh_act;
	logic [7:0] sh_b_q;
	logic       sh_eoi_q;
	assign sh_act  = talk_q & ~atn & ~ifc & ~link_usb_q;
	assign sh_done = sh_act && sh_q == remote_bus_pkg::SH_DAV && ndac_n_i;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sh_q     <= remote_bus_pkg::SH_IDLE;
			sh_b_q   <= 8'h00;
			sh_eoi_q <= 1'b0;
			sh_sp_q  <= 1'b0;
		end else begin
			case (sh_q)
				remote_bus_pkg::SH_IDLE: begin
					if (sh_act && (spoll_q || out_v)) begin
						sh_q     <= remote_bus_pkg::SH_SET;
						sh_sp_q  <= spoll_q;
						sh_b_q   <= spoll_q ? {1'b0, rqs_q, stb_q} : out_b;
						sh_eoi_q <= ~spoll_q & out_end & eoi_en_q;
					end
				end
				remote_bus_pkg::SH_SET: begin
					if (!sh_act) begin
						sh_q <= remote_bus_pkg::SH_IDLE;
					end else if (nrfd_n_i) begin
						sh_q <= remote_bus_pkg::SH_DAV;
					end
				end
				remote_bus_pkg::SH_DAV: begin
					if (!sh_act || ndac_n_i) begin
						sh_q <= remote_bus_pkg::SH_IDLE;
					end
				end
				default: sh_q <= remote_bus_pkg::SH_IDLE;
			endcase
		end
	end

	assign dio_n_oe_n = (sh_q != remote_bus_pkg::SH_IDLE && sh_act) ? ~sh_b_q : 8'hFF;
	assign dav_n_oe_n = ~(sh_act && sh_q == remote_bus_pkg::SH_DAV);
	assign eoi_n_oe_n = ~(sh_act && sh_q != remote_bus_pkg::SH_IDLE && sh_eoi_q);

	// Service request and status byte
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			stb_q <= 6'h00;
			rqs_q <= 1'b0;
		end else begin
			if (dev_clr || (sh_done && sh_sp_q)) begin
				rqs_q <= 1'b0;
			end
			if (reg_wr && reg_addr == remote_bus_pkg::OFS_STB) begin
				stb_q <= reg_wdata[5:0];
				if (reg_wdata[remote_bus_pkg::STB_SRQ_BIT]) begin
					rqs_q <= 1'b1;
				end
			end
		end
	end
	assign srq_n_oe_n = ~rqs_q;

	// Receive path
	logic       usb_in, rx_v, rx_eol, rx_bad, rx_exec;
	logic [7:0] rx_b;
	assign usb_rx_ready = ~full;
	assign usb_in  = usb_rx_valid & ~full;
	assign rx_v    = gp_data_v | usb_in;
	assign rx_b    = gp_data_v ? bus_byte : usb_rx_data;
	assign rx_eol  = rx_b == remote_bus_pkg::CHR_LF || rx_b == remote_bus_pkg::CHR_CR;
	assign rx_bad  = rx_b < remote_bus_pkg::CHR_LO || rx_b > remote_bus_pkg::CHR_HI;
	assign rx_exec = rx_b == remote_bus_pkg::CHR_EXEC;

	always_ff @(posedge clk_sys) begin
		if (rx_v && !rx_eol && !rx_bad && !rx_exec) begin
			mem[wp_q[PW-2:0]] <= rx_b;
		end
	end

	logic pop;
	assign pop = reg_rd && reg_addr == remote_bus_pkg::OFS_RXD && rp_q != cp_q;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wp_q  <= '0;
			cp_q  <= '0;
			rp_q  <= '0;
			err_q <= 1'b0;
		end else if (dev_clr) begin
			wp_q  <= '0;
			cp_q  <= '0;
			rp_q  <= '0;
			err_q <= 1'b0;
		end else begin
			if (pop) begin
				rp_q <= rp_q + 1'b1;
			end
			if (rx_v && !rx_eol) begin
				if (rx_exec) begin
					if (err_q) begin
						wp_q <= cp_q;
					end else begin
						cp_q <= wp_q;
					end
					err_q <= 1'b0;
				end else if (rx_bad) begin
					err_q <= 1'b1;
				end else begin
					wp_q <= wp_q + 1'b1;
				end
			end
		end
	end

	// Remote and local state
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			remote_q   <= 1'b0;
			llo_q      <= 1'b0;
			link_usb_q <= 1'b0;
			ren_prev_q <= 1'b0;
			usb_prev_q <= 1'b0;
		end else begin
			ren_prev_q <= ren;
			usb_prev_q <= usb_attached;
			if (usb_rx_valid) begin
				link_usb_q <= 1'b1;
			end else if (gp_data_v || mla || mta) begin
				link_usb_q <= 1'b0;
			end
			if (!ren) begin
				llo_q <= 1'b0;
			end else if (cmd_v && cmd == remote_bus_pkg::MSG_LLO) begin
				llo_q <= 1'b1;
			end
			if (gtl_hit || (ren_prev_q && !ren)) begin
				remote_q <= 1'b0;
			end
			if (usb_prev_q && !usb_attached) begin
				remote_q <= 1'b0;
			end
			if (panel_local && !(llo_q && !link_usb_q)) begin
				remote_q <= 1'b0;
			end
			if (usb_rx_valid || (ren && (gp_data_v || mla))) begin
				remote_q <= 1'b1;
			end
		end
	end

	assign remote_ind  = remote_q;
	assign panel_op_ok = panel_op & (~remote_q | panel_browse | panel_local);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			restore_q <= 1'b0;
		end else begin
			restore_q <= dev_clr;
		end
	end
	assign settings_restore = restore_q;

	// Configuration register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			addr_q   <= remote_bus_pkg::ADDR_RST;
			term_q   <= remote_bus_pkg::TERM_RST;
			eoi_en_q <= remote_bus_pkg::EOI_RST;
		end else if (reg_wr && reg_addr == remote_bus_pkg::OFS_CTRL) begin
			if (reg_wdata[4:0] <= remote_bus_pkg::ADDR_MAX) begin
				addr_q <= reg_wdata[4:0];
			end
			term_q   <= reg_wdata[remote_bus_pkg::CTRL_TERM_LSB +: 2];
			eoi_en_q <= reg_wdata[remote_bus_pkg::CTRL_EOI_BIT];
		end
	end

	// Sticky events, cleared by read, set wins
	logic [2:0] evt_set;
	assign evt_set = {usb_rx_valid & full, rx_v & rx_exec & err_q, dev_clr};
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			evt_q <= 3'h0;
		end else if (reg_rd && reg_addr == remote_bus_pkg::OFS_EVT) begin
			evt_q <= evt_set;
		end else begin
			evt_q <= evt_q | evt_set;
		end
	end

	// Register read data
	logic [7:0] avail;
	logic [PW-1:0] avail_w;
	assign avail_w = cp_q - rp_q;
	assign avail   = 8'(avail_w);
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				remote_bus_pkg::OFS_CTRL: reg_rdata <= {8'h00, eoi_en_q, term_q, addr_q};
				remote_bus_pkg::OFS_STAT: reg_rdata <= {avail, rqs_q, out_v, err_q,
					spoll_q, talk_q, listen_q, llo_q, remote_q};
				remote_bus_pkg::OFS_RXD:  reg_rdata <= {7'h00, rp_q != cp_q,
					mem[rp_q[PW-2:0]]};
				remote_bus_pkg::OFS_STB:  reg_rdata <= {9'h000, rqs_q, stb_q};
				remote_bus_pkg::OFS_EVT:  reg_rdata <= {13'h0000, evt_q};
				default:                  reg_rdata <= 16'h0000;
			endcase
		end
	end

endmodule : remote_local_bus_interface

// [testbench/bus_ctl_model.sv]
`timescale 1ns/1ps
module bus_ctl_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] dio_w,
	input  wire logic       dav_w,
	input  wire logic       nrfd_w,
	input  wire logic       ndac_w,
	output logic      [7:0] dio_n,
	output logic            dav_n,
	output logic            nrfd_n,
	output logic            ndac_n,
	output logic            atn_n,
	output logic            ren_n,
	output logic            ifc_n
);
	// One controller, one device at its own address, short messages only
	initial begin
		{dio_n, dav_n, nrfd_n, ndac_n, atn_n, ren_n, ifc_n} = '1;
	end

	task automatic lines(input logic ren, input logic ifc);
		@(posedge clk_sys);
		ren_n <= !ren;
		ifc_n <= !ifc;
	endtask : lines

	// Source handshake as controller
	task automatic send(input logic atn, input logic [7:0] b);
		@(posedge clk_sys);
		atn_n  <= !atn;
		dio_n  <= ~b;
		nrfd_n <= 1'b1;
		ndac_n <= 1'b1;
		do @(negedge clk_sys); while (!nrfd_w);
		@(posedge clk_sys) dav_n <= 1'b0;
		do @(negedge clk_sys); while (!ndac_w);
		@(posedge clk_sys);
		dav_n <= 1'b1;
		dio_n <= 8'hFF;
		@(negedge clk_sys);
	endtask : send

	// Acceptor handshake with a stall before accept
	task automatic recv(output logic [7:0] b);
		@(posedge clk_sys);
		ndac_n <= 1'b0;
		nrfd_n <= 1'b0;
		atn_n  <= 1'b1;
		@(posedge clk_sys) nrfd_n <= 1'b1;
		do @(negedge clk_sys); while (dav_w);
		b = ~dio_w;
		repeat (3) @(posedge clk_sys);
		nrfd_n <= 1'b0;
		ndac_n <= 1'b1;
		do @(negedge clk_sys); while (!dav_w);
		@(posedge clk_sys) ndac_n <= 1'b0;
		@(negedge clk_sys);
	endtask : recv
endmodule : bus_ctl_model

// [testbench/remote_local_bus_interface_properties.sv]
`timescale 1ns/1ps
module remote_bus_checker (
	input wire logic       clk_sys,
	input wire logic       rstn,
	input wire logic [7:0] dio_n_o,
	input wire logic [7:0] dio_n_oe_n,
	input wire logic       dav_n_i,
	input wire logic       dav_n_o,
	input wire logic       dav_n_oe_n,
	input wire logic       nrfd_n_i,
	input wire logic       nrfd_n_o,
	input wire logic       ndac_n_i,
	input wire logic       ndac_n_o,
	input wire logic       eoi_n_o,
	input wire logic       srq_n_o,
	input wire logic       srq_n_oe_n,
	input wire logic       atn_n_i,
	input wire logic       ifc_n_i,
	input wire logic       ren_n_i,
	input wire logic       usb_attached,
	input wire logic       usb_rx_valid,
	input wire logic       usb_rx_ready,
	input wire logic       panel_op,
	input wire logic       panel_browse,
	input wire logic       panel_local,
	input wire logic       panel_op_ok,
	input wire logic       remote_ind,
	input wire logic       settings_restore
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	a_usb_remote: assert property (usb_rx_valid && usb_rx_ready |-> ##[1:2] remote_ind)
		else $error("remote not entered after usb byte");
	a_detach_local: assert property ($fell(usb_attached) && !usb_rx_valid && dav_n_i |-> ##[1:2] !remote_ind)
		else $error("remote kept after usb detach");
	a_ren_local: assert property ($rose(ren_n_i) && !usb_rx_valid |-> ##[1:2] !remote_ind)
		else $error("remote kept after remote enable false");
	a_panel_remote: assert property (remote_ind && panel_op && !panel_browse && !panel_local |-> !panel_op_ok)
		else $error("panel action accepted in remote");
	a_panel_local: assert property (!remote_ind && panel_op |-> panel_op_ok)
		else $error("panel action refused in local");
	a_open_coll: assert property (dio_n_o == 8'h00 && !(dav_n_o | nrfd_n_o | ndac_n_o | eoi_n_o | srq_n_o))
		else $error("bus driver not open collector");
	a_dav_after_rfd: assert property ($fell(dav_n_oe_n) |-> $past(nrfd_n_i))
		else $error("data valid before ready for data");
	a_dav_hold: assert property (!dav_n_oe_n && !ndac_n_i && atn_n_i && ifc_n_i |=> !dav_n_oe_n)
		else $error("data valid dropped before accept");
	a_data_stable: assert property (!dav_n_oe_n && atn_n_i && ifc_n_i |=> dav_n_oe_n || $stable(dio_n_oe_n))
		else $error("data lines changed under data valid");
	a_ifc_release: assert property (!ifc_n_i [*2] |-> dio_n_oe_n == 8'hFF && dav_n_oe_n)
		else $error("bus lines held during interface clear");
	a_restore_pulse: assert property (settings_restore |=> !settings_restore)
		else $error("settings restore longer than one cycle");

	c_remote: cover property ($rose(remote_ind));
	c_restore: cover property (settings_restore);
	c_srq_done: cover property ($rose(srq_n_oe_n));
endmodule : remote_bus_checker

bind remote_local_bus_interface remote_bus_checker chk_i (
	.clk_sys, .rstn, .dio_n_o, .dio_n_oe_n, .dav_n_i, .dav_n_o, .dav_n_oe_n, .nrfd_n_i,
	.nrfd_n_o, .ndac_n_i, .ndac_n_o, .eoi_n_o, .srq_n_o, .srq_n_oe_n, .atn_n_i, .ifc_n_i,
	.ren_n_i, .usb_attached, .usb_rx_valid, .usb_rx_ready, .panel_op, .panel_browse,
	.panel_local, .panel_op_ok, .remote_ind, .settings_restore
);

// [testbench/tb_remote_local_bus_interface.sv]
`timescale 1ns/1ps
module tb_remote_local_bus_interface;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0;
	logic [4:0]  reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata, rd_d;
	logic [7:0]  dio_oe_n, h_dio, pb;
	logic        dav_oe_n, nrfd_oe_n, ndac_oe_n, eoi_oe_n, srq_oe_n;
	logic        h_dav, h_nrfd, h_ndac, atn_n, ifc_n, ren_n;
	logic        usb_attached = 1'b1;
	logic [7:0]  usb_rx_data = 8'h00;
	logic        usb_rx_valid = 1'b0;
	logic        usb_tx_ready = 1'b1;
	logic        panel_op = 1'b0;
	logic        panel_browse = 1'b0;
	logic        panel_local = 1'b0;
	logic        usb_rx_ready, panel_op_ok, remote_ind, settings_restore;
	logic [7:0]  usb_tx_data;
	logic        usb_tx_valid;
	logic [23:0] tx_log = 24'h000000;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          restores = 0;
	// Pulled-up bus lines: any party may pull low
	wire logic [7:0] dio_w = h_dio & dio_oe_n;
	wire logic       dav_w = h_dav & dav_oe_n;
	wire logic       nrfd_w = h_nrfd & nrfd_oe_n;
	wire logic       ndac_w = h_ndac & ndac_oe_n;

	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (settings_restore === 1'b1) restores++;
	always @(posedge clk_sys) if (usb_tx_valid === 1'b1 && usb_tx_ready) tx_log <= {tx_log[15:0], usb_tx_data};

	remote_local_bus_interface dut (
		.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.dio_n_i(dio_w), .dio_n_o(), .dio_n_oe_n(dio_oe_n), .dav_n_i(dav_w), .dav_n_o(),
		.dav_n_oe_n(dav_oe_n), .nrfd_n_i(nrfd_w), .nrfd_n_o(), .nrfd_n_oe_n(nrfd_oe_n),
		.ndac_n_i(ndac_w), .ndac_n_o(), .ndac_n_oe_n(ndac_oe_n), .eoi_n_i(eoi_oe_n),
		.eoi_n_o(), .eoi_n_oe_n(eoi_oe_n), .srq_n_o(), .srq_n_oe_n(srq_oe_n),
		.atn_n_i(atn_n), .ifc_n_i(ifc_n), .ren_n_i(ren_n), .usb_attached, .usb_rx_data,
		.usb_rx_valid, .usb_rx_ready, .usb_tx_data, .usb_tx_valid, .usb_tx_ready,
		.panel_op, .panel_browse, .panel_local, .panel_op_ok, .remote_ind, .settings_restore
	);

	bus_ctl_model host (
		.clk_sys, .dio_w, .dav_w, .nrfd_w, .ndac_w, .dio_n(h_dio), .dav_n(h_dav),
		.nrfd_n(h_nrfd), .ndac_n(h_ndac), .atn_n, .ren_n, .ifc_n
	);

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys) reg_wr <= 1'b0;
		@(negedge clk_sys);
	endtask : wr

	task automatic rc(input logic [4:0] a, input logic [15:0] m, e, input string n);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys) reg_rd <= 1'b0;
		@(negedge clk_sys) rd_d = reg_rdata;
		chk(n, e, rd_d & m);
	endtask : rc

	task automatic usb(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge clk_sys);
			usb_rx_data  <= s[i];
			usb_rx_valid <= 1'b1;
			do @(negedge clk_sys); while (usb_rx_ready !== 1'b1);
			@(posedge clk_sys) usb_rx_valid <= 1'b0;
			@(negedge clk_sys);
		end
	endtask : usb

	task automatic panel(input logic b, input logic e);
		@(posedge clk_sys);
		panel_op     <= 1'b1;
		panel_browse <= b;
		@(negedge clk_sys) chk("panel_op_ok", {15'h0000, e}, {15'h0000, panel_op_ok});
		@(posedge clk_sys) panel_op <= 1'b0;
		@(negedge clk_sys);
	endtask : panel

	task automatic go_local;
		@(posedge clk_sys) panel_local <= 1'b1;
		@(posedge clk_sys) panel_local <= 1'b0;
		@(negedge clk_sys);
	endtask : go_local

	task automatic rem(input logic e);
		repeat (3) @(negedge clk_sys);
		chk("remote_ind", {15'h0000, e}, {15'h0000, remote_ind});
	endtask : rem

	task automatic conclude;
		$display("mismatches %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		conclude;
	end

	initial begin
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		rc(remote_bus_pkg::OFS_CTRL, 16'hFFFF, 16'h0082, "ctrl reset");
		rc(remote_bus_pkg::OFS_STAT, 16'hFFFF, 16'h0000, "stat reset");
		rc(5'h18, 16'hFFFF, 16'h0000, "unmapped");
		wr(remote_bus_pkg::OFS_CTRL, 16'h009F);
		rc(remote_bus_pkg::OFS_CTRL, 16'h00FF, 16'h0082, "addr over 30");
		wr(remote_bus_pkg::OFS_CTRL, 16'h0045);
		rc(remote_bus_pkg::OFS_CTRL, 16'h00FF, 16'h0045, "ctrl set");
		wr(remote_bus_pkg::OFS_CTRL, 16'h0082);
		usb("\rA\nX");
		rem(1'b1);
		wr(remote_bus_pkg::OFS_TXD, 16'h0141);
		repeat (4) @(negedge clk_sys);
		chk("usb byte", 16'h0041, {8'h00, tx_log[23:16]});
		chk("usb terminator", 16'h0D0A, tx_log[15:0]);
		panel(1'b0, 1'b0);
		panel(1'b1, 1'b1);
		rc(remote_bus_pkg::OFS_RXD, 16'h01FF, 16'h0141, "rx byte");
		rc(remote_bus_pkg::OFS_RXD, 16'h0100, 16'h0000, "rx empty");
		usb("\001CX");
		rc(remote_bus_pkg::OFS_EVT, 16'h0002, 16'h0002, "error event");
		rc(remote_bus_pkg::OFS_RXD, 16'h0100, 16'h0000, "rx discarded");
		go_local;
		rem(1'b0);
		panel(1'b0, 1'b1);
		usb("A");
		rem(1'b1);
		@(posedge clk_sys) usb_attached <= 1'b0;
		rem(1'b0);
		host.lines(1'b1, 1'b0);
		host.send(1'b1, 8'h22);
		host.send(1'b0, 8'h44);
		rem(1'b1);
		rc(remote_bus_pkg::OFS_STAT, 16'h000E, 16'h0004, "listener");
		host.send(1'b1, {1'b0, remote_bus_pkg::MSG_LLO});
		go_local;
		rem(1'b1);
		rc(remote_bus_pkg::OFS_STAT, 16'h0002, 16'h0002, "lockout");
		host.send(1'b1, {1'b0, remote_bus_pkg::MSG_GTL});
		rem(1'b0);
		host.send(1'b0, 8'h45);
		rem(1'b1);
		host.lines(1'b0, 1'b0);
		rem(1'b0);
		host.lines(1'b1, 1'b0);
		host.send(1'b1, 8'h42);
		rc(remote_bus_pkg::OFS_STAT, 16'h000C, 16'h0008, "talker");
		wr(remote_bus_pkg::OFS_STB, 16'h0045);
		repeat (2) @(negedge clk_sys);
		chk("srq pending", 16'h0000, {15'h0000, srq_oe_n});
		host.send(1'b1, {1'b0, remote_bus_pkg::MSG_SPE});
		host.recv(pb);
		chk("poll byte", 16'h0045, {8'h00, pb});
		chk("poll eoi", 16'h0001, {15'h0000, eoi_oe_n});
		repeat (3) @(negedge clk_sys);
		chk("srq released", 16'h0001, {15'h0000, srq_oe_n});
		host.send(1'b1, {1'b0, remote_bus_pkg::MSG_SPD});
		host.send(1'b1, 8'h22);
		rc(remote_bus_pkg::OFS_STAT, 16'h000C, 16'h0004, "talker dropped");
		host.send(1'b1, {1'b0, remote_bus_pkg::MSG_DCL});
		repeat (3) @(negedge clk_sys);
		chk("restore count", 16'h0001, restores[15:0]);
		rc(remote_bus_pkg::OFS_EVT, 16'h0001, 16'h0001, "clear event");
		host.lines(1'b1, 1'b1);
		repeat (2) @(posedge clk_sys);
		host.lines(1'b1, 1'b0);
		rc(remote_bus_pkg::OFS_STAT, 16'h000C, 16'h0000, "ifc unaddress");
		host.send(1'b1, 8'h25);
		rc(remote_bus_pkg::OFS_STAT, 16'h000C, 16'h0000, "other address");
		conclude;
	end
endmodule : tb_remote_local_bus_interface
